// file: hw/uop_programmer.sv
// user region programmer: mirrors, write-enable register, storage writer,
// lock flags and background change detection on locked regions, on zero and one only while the shared base points there
// assumes all ports share one clock; the storage takes one byte per strobe
module uop_programmer
  import uop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mir_wr_valid, // user register write into a region block
  input wire logic [1:0] mir_wr_region,
  input wire logic [3:0] mir_wr_index,
  input wire logic [7:0] mir_wr_data,
  input wire logic wen_wr_valid, // write to the write-enable register
  input wire logic [7:0] wen_wr_data,
  input wire logic [1:0] rd_region, // mirror read-back select
  input wire logic [3:0] rd_index,
  output logic [7:0] rd_data_r,
  output logic [7:0] wen_r, // write-enable register contents
  output logic busy_r,
  output logic [2:0] lock_r, // lock flag per region
  output logic [2:0] error_r, // sticky change detected per region
  output logic shared_base_r, // which region the shared block serves
  output logic nv_strobe_r, // one storage byte write
  output logic [1:0] nv_region_r,
  output logic [4:0] nv_index_r, // 16 = check code byte
  output logic [7:0] nv_data_r
);
  logic [7:0] shared_mem [NUM_REGS]; // mirror for regions zero and one
  logic [7:0] two_mem [NUM_REGS]; // mirror for region two
  logic [7:0] check_r [3]; // stored check code per region
  logic [1:0] excl_r; // region two exclusions kept at lock, {proto, pos}
  uop_state_t state_r, state_nxt;
  logic [4:0] idx_r, idx_nxt; // byte position of the running job
  logic [1:0] job_region_r;
  logic job_exproto_r, job_expos_r;
  logic [7:0] crc_r; // running check code of the job
  logic [1:0] scan_reg_r; // background scan position
  logic [3:0] scan_idx_r;
  logic [7:0] scan_crc_r;

  // decode of the write-enable register write
  wire [1:0] wr_region = wen_wr_data[REGION_LSB +: 2];
  wire wr_trigger = wen_wr_valid && wen_wr_data[TRIG_BIT] && !busy_r;
  wire wr_rsvd = (wr_region == REGION_RSVD);
  // padded so the reserved code never indexes past the three lock flags
  wire [3:0] lock_ext = {1'h0, lock_r};
  wire start = wr_trigger && !wr_rsvd && !lock_ext[wr_region];
  // job byte fetch with exclusion substitution
  wire job_is_two = (job_region_r == REGION_TWO);
  wire [7:0] job_raw = job_is_two ? two_mem[idx_r[3:0]] : shared_mem[idx_r[3:0]];
  wire job_excl = job_is_two && ((job_exproto_r && idx_r[3:0] == PROTO_IDX)
                  || (job_expos_r && idx_r[3:0] == POS_IDX));
  wire [7:0] job_data = job_excl ? MEM_RESET : job_raw;
  wire skip_byte = job_excl && (idx_r != CHECK_IDX);
  wire [7:0] crc_nxt;
  wire tmr_load = (state_r == UOP_PROG) && !skip_byte;
  wire tmr_done;
  // background scan byte with the same substitution as at programming
  wire scan_is_two = (scan_reg_r == REGION_TWO);
  wire [7:0] scan_raw = scan_is_two ? two_mem[scan_idx_r] : shared_mem[scan_idx_r];
  wire scan_excl = scan_is_two && ((excl_r[1] && scan_idx_r == PROTO_IDX)
                   || (excl_r[0] && scan_idx_r == POS_IDX));
  wire [7:0] scan_byte = scan_excl ? MEM_RESET : scan_raw;
  wire [7:0] scan_crc_nxt;
  wire scan_last = (scan_idx_r == 4'hF);
  // the shared block only holds a region's data while the base points there
  wire scan_valid = scan_is_two || (shared_base_r == scan_reg_r[0]);
  wire scan_mismatch = scan_last && lock_r[scan_reg_r] && scan_valid
                       && (scan_crc_nxt != check_r[scan_reg_r]);
  wire [1:0] scan_reg_nxt = scan_is_two ? REGION_ZERO : scan_reg_r + 2'h1;
  // user writes only land in mirrors, and not during a job
  wire mir_take = mir_wr_valid && !busy_r && (mir_wr_region != REGION_RSVD);
  wire [7:0] rd_data_nxt = (rd_region == REGION_RSVD) ? MEM_RESET
                           : (rd_region == REGION_TWO) ? two_mem[rd_index] : shared_mem[rd_index];

  uop_crc8 u_job_crc (
    .crc_in(crc_r),
    .data_in(job_data),
    .crc_out(crc_nxt)
  );

  uop_crc8 u_scan_crc (
    .crc_in(scan_crc_r),
    .data_in(scan_byte),
    .crc_out(scan_crc_nxt)
  );

  uop_timer u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .load(tmr_load),
    .done(tmr_done)
  );

  // job sequencer: check code first, then one byte per storage write, then lock
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    unique case (state_r)
      UOP_IDLE: begin
        if (start) begin
          state_nxt = UOP_CALC;
          idx_nxt = 5'h00;
        end
      end
      UOP_CALC: begin
        if (idx_r == LAST_IDX) begin
          state_nxt = UOP_PROG;
          idx_nxt = 5'h00;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      UOP_PROG: begin
        if (skip_byte) begin
          idx_nxt = idx_r + 5'h01; // excluded byte never reaches storage
        end else begin
          state_nxt = UOP_WAIT;
        end
      end
      UOP_WAIT: begin
        if (tmr_done && idx_r == CHECK_IDX) begin
          state_nxt = UOP_LOCK;
        end else if (tmr_done) begin
          state_nxt = UOP_PROG;
          idx_nxt = idx_r + 5'h01;
        end
      end
      UOP_LOCK: begin
        state_nxt = UOP_IDLE;
      end
      default: begin
        state_nxt = UOP_IDLE; // unused codes recover to idle
        idx_nxt = 5'h00;
      end
    endcase
  end

  // state, index and busy flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= UOP_IDLE;
      idx_r <= 5'h00;
      busy_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      busy_r <= (state_nxt != UOP_IDLE);
    end
  end

  // job parameters caught at the trigger
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      job_region_r <= REGION_ZERO;
      job_exproto_r <= 1'h0;
      job_expos_r <= 1'h0;
    end else if (start) begin
      job_region_r <= wr_region;
      job_exproto_r <= wen_wr_data[EXPROTO_BIT];
      job_expos_r <= wen_wr_data[EXPOS_BIT];
    end
  end

  // write-enable register; never cleared by the job itself
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wen_r <= WEN_RESET;
    end else if (wen_wr_valid && !busy_r) begin
      wen_r <= wen_wr_data;
    end
  end

  // running check code over the job bytes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crc_r <= CRC_INIT;
    end else if (start) begin
      crc_r <= CRC_INIT;
    end else if (state_r == UOP_CALC) begin
      crc_r <= crc_nxt;
    end
  end

  // storage write port; data is read from a mirror that user writes cannot change while busy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nv_strobe_r <= 1'h0;
      nv_region_r <= REGION_ZERO;
      nv_index_r <= 5'h00;
      nv_data_r <= MEM_RESET;
    end else begin
      nv_strobe_r <= tmr_load;
      if (tmr_load) begin
        nv_region_r <= job_region_r;
        nv_index_r <= idx_r;
        nv_data_r <= (idx_r == CHECK_IDX) ? crc_r : job_data;
      end
    end
  end

  // lock flags, stored check codes and kept exclusions
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= 3'h0;
      excl_r <= 2'h0;
      for (int r = 0; r < 3; r++) begin
        check_r[r] <= CRC_INIT;
      end
    end else if (state_r == UOP_LOCK) begin
      lock_r[job_region_r] <= 1'h1;
      check_r[job_region_r] <= crc_r;
      if (job_is_two) begin
        excl_r <= {job_exproto_r, job_expos_r};
      end
    end
  end

  // mirrors; writes stay open after lock, only storage is closed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shared_base_r <= 1'h0;
      for (int i = 0; i < NUM_REGS; i++) begin
        shared_mem[i] <= MEM_RESET;
        two_mem[i] <= MEM_RESET;
      end
    end else if (state_r == UOP_LOCK && job_is_two && job_expos_r) begin
      two_mem[POS_IDX] <= MEM_RESET;
    end else if (mir_take && mir_wr_region == REGION_TWO) begin
      two_mem[mir_wr_index] <= mir_wr_data;
    end else if (mir_take) begin
      shared_mem[mir_wr_index] <= mir_wr_data; // old bytes stay in place
      shared_base_r <= mir_wr_region[0];
    end
  end

  // background scan, restarted by a job: bytes read before the lock and the
  // new exclusions would otherwise be judged against the new check code
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_reg_r <= REGION_ZERO;
      scan_idx_r <= 4'h0;
      scan_crc_r <= CRC_INIT;
      error_r <= 3'h0;
    end else if (busy_r) begin
      scan_idx_r <= 4'h0; // region scanned again from its first byte
      scan_crc_r <= CRC_INIT;
    end else begin
      scan_idx_r <= scan_idx_r + 4'h1;
      scan_crc_r <= scan_last ? CRC_INIT : scan_crc_nxt;
      if (scan_last) begin
        scan_reg_r <= scan_reg_nxt;
      end
      if (scan_mismatch) begin
        error_r[scan_reg_r] <= 1'h1;
      end
    end
  end

  // registered read-back
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= MEM_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // checks
  trig_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == UOP_LOCK |=> wen_r[TRIG_BIT] && lock_r[job_region_r]) else $error("trigger bit or lock lost");
  lock_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(lock_r[2]) |-> $past(state_r) == UOP_LOCK && job_is_two) else $error("region two lock without job");
  pos_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == UOP_LOCK && job_is_two && job_expos_r |=> two_mem[POS_IDX] == MEM_RESET)
    else $error("position not zero after write");
  rsvd_noop_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_r == UOP_IDLE && wr_trigger && wr_rsvd |=> state_r == UOP_IDLE ##1 !nv_strobe_r)
    else $error("reserved region started a job");
  locked_noop_a: assert property (@(posedge clock) disable iff (!rst_b)
    wr_trigger && lock_ext[wr_region] |=> !busy_r) else $error("locked region restarted");
  busy_block_a: assert property (@(posedge clock) disable iff (!rst_b)
    busy_r && wen_wr_valid |=> $stable(wen_r) && $stable(job_region_r)) else $error("trigger taken while busy");
  proto_skip_a: assert property (@(posedge clock) disable iff (!rst_b)
    nv_strobe_r && job_is_two && job_exproto_r |-> nv_index_r[3:0] != PROTO_IDX || nv_index_r == CHECK_IDX)
    else $error("excluded protocol byte stored");
  byte_gap_a: assert property (@(posedge clock) disable iff (!rst_b)
    nv_strobe_r |=> !nv_strobe_r [*8]) else $error("storage writes too close");
  copy_data_a: assert property (@(posedge clock) disable iff (!rst_b)
    nv_strobe_r && nv_index_r != CHECK_IDX && nv_region_r != REGION_TWO
    |-> nv_data_r == shared_mem[nv_index_r[3:0]]) else $error("stored byte differs from mirror");
  only_busy_a: assert property (@(posedge clock) disable iff (!rst_b)
    nv_strobe_r |-> busy_r) else $error("storage write outside a job");
  base_move_a: assert property (@(posedge clock) disable iff (!rst_b)
    mir_take && mir_wr_region == REGION_ONE |=> shared_base_r) else $error("shared base not moved");
  err_locked_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(error_r[2]) |-> lock_r[2]) else $error("error on unlocked region");
  zero_done_c: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == UOP_LOCK && job_region_r == REGION_ZERO);
  two_expos_c: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == UOP_LOCK && job_is_two && job_expos_r);
  rsvd_try_c: cover property (@(posedge clock) disable iff (!rst_b) wr_trigger && wr_rsvd);
  err_seen_c: cover property (@(posedge clock) disable iff (!rst_b) $rose(error_r[2]));
endmodule // uop_programmer

// file: hw/uop_pkg.sv
// constants, field layout and state type for the user region programmer
// assumes one 125 MHz clock and an async active-low reset in every clocked user
package uop_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8; // 125 MHz
  localparam int unsigned BYTE_PROG_NS = 100; // one storage byte write, least
  localparam int unsigned BYTE_PROG_CYC = (BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] BYTE_PROG_CNT = 5'(BYTE_PROG_CYC);
  localparam int unsigned NUM_REGS = 16; // registers per region block
  localparam int unsigned TRIG_BIT = 7; // write-enable register fields
  localparam int unsigned EXPROTO_BIT = 3;
  localparam int unsigned EXPOS_BIT = 2;
  localparam int unsigned REGION_LSB = 0;
  localparam logic [7:0] WEN_RESET = 8'h00;
  localparam logic [1:0] REGION_ZERO = 2'h0;
  localparam logic [1:0] REGION_ONE = 2'h1;
  localparam logic [1:0] REGION_TWO = 2'h2;
  localparam logic [1:0] REGION_RSVD = 2'h3;
  localparam logic [3:0] PROTO_IDX = 4'h0; // protocol_select_reg in region two
  localparam logic [3:0] POS_IDX = 4'h1; // bus_position_reg in region two
  localparam logic [4:0] LAST_IDX = 5'h0F;
  localparam logic [4:0] CHECK_IDX = 5'h10; // check code byte slot
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] MEM_RESET = 8'h00;
  typedef enum logic [2:0] {UOP_IDLE, UOP_CALC, UOP_PROG, UOP_WAIT, UOP_LOCK} uop_state_t;
endpackage : uop_pkg

// file: hw/uop_crc8.sv
// one byte step of the check code, purely combinational
// assumes the caller holds the running value in its own register
module uop_crc8
  import uop_pkg::*;
(
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  // msb-first shift, one bit per loop pass
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ({c[6:0], 1'h0} ^ CRC_POLY) : {c[6:0], 1'h0};
    end
    crc_out = c;
  end
endmodule // uop_crc8

// file: hw/uop_timer.sv
// down counter that marks the end of one storage byte write
// assumes load is a one-cycle pulse and never comes while counting
module uop_timer
  import uop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic load,
  output logic done
);
  logic [4:0] count_r; // remaining cycles, zero when idle

  // done marks the last waiting cycle
  assign done = (count_r == 5'h01);

  // load wins; otherwise count down to zero and stay
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 5'h00;
    end else if (load) begin
      count_r <= BYTE_PROG_CNT;
    end else if (count_r != 5'h00) begin
      count_r <= count_r - 5'h01;
    end
  end
endmodule // uop_timer

// file: verif/tb.sv
// self-checking bench for the user region programmer, no partner model
// assumes the design package and the programmer with its inline checks are compiled first
module tb import uop_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0; // 125 MHz
  logic rst_b = 1'b0; // active low
  logic mir_wr_valid = 1'b0;
  logic [1:0] mir_wr_region = 2'h0;
  logic [3:0] mir_wr_index = 4'h0;
  logic [7:0] mir_wr_data = 8'h00;
  logic wen_wr_valid = 1'b0;
  logic [7:0] wen_wr_data = 8'h00;
  logic [1:0] rd_region = 2'h0;
  logic [3:0] rd_index = 4'h0;
  logic [7:0] rd_data_r, wen_r, nv_data_r;
  logic busy_r, shared_base_r, nv_strobe_r;
  logic [2:0] lock_r, error_r;
  logic [1:0] nv_region_r;
  logic [4:0] nv_index_r;
  int n_mismatch = 0; // failed comparisons
  int checks = 0; // all comparisons
  int cycles = 0; // timeout counter
  logic [7:0] sh[16]; // model of the shared block
  logic [7:0] tw[16]; // model of the region two block

  uop_programmer i_dut (.clock(clock), .rst_b(rst_b), .mir_wr_valid(mir_wr_valid), .mir_wr_region(mir_wr_region),
    .mir_wr_index(mir_wr_index), .mir_wr_data(mir_wr_data), .wen_wr_valid(wen_wr_valid),
    .wen_wr_data(wen_wr_data), .rd_region(rd_region), .rd_index(rd_index), .rd_data_r(rd_data_r),
    .wen_r(wen_r), .busy_r(busy_r), .lock_r(lock_r), .error_r(error_r), .shared_base_r(shared_base_r),
    .nv_strobe_r(nv_strobe_r), .nv_region_r(nv_region_r), .nv_index_r(nv_index_r), .nv_data_r(nv_data_r));

  // free running clock
  always #4 clock = ~clock;

  // hang guard: six jobs need well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // reset for three edges, model cleared to mirror reset value
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (3) @(posedge clock);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 16; i++) begin
      sh[i] = 8'h00;
      tw[i] = 8'h00;
    end
  endtask

  // one-cycle mirror write; storage must stay quiet
  task automatic mwr(input logic [1:0] r, input logic [3:0] i, input logic [7:0] d);
    @(posedge clock);
    #1 mir_wr_valid = 1'b1;
    mir_wr_region = r;
    mir_wr_index = i;
    mir_wr_data = d;
    @(posedge clock);
    #1 mir_wr_valid = 1'b0;
    chk(nv_strobe_r, 1'b0);
    if (r == 2'h2) tw[i] = d;
    else sh[i] = d;
  endtask

  // mirror read, result settled after two edges
  task automatic rd(input logic [1:0] r, input logic [3:0] i, input logic [7:0] e);
    @(posedge clock);
    #1 rd_region = r;
    rd_index = i;
    repeat (2) @(posedge clock);
    #1 chk(rd_data_r, e);
  endtask

  task automatic wen(input logic [7:0] d);
    @(posedge clock);
    #1 wen_wr_valid = 1'b1;
    wen_wr_data = d;
    @(posedge clock);
    #1 wen_wr_valid = 1'b0;
  endtask

  // expected stored byte; excluded region two bytes count as zero
  function automatic logic [7:0] sbyte(input logic [7:0] d, input int i);
    if (d[1:0] != 2'h2) return sh[i];
    if ((i == 0 && d[3]) || (i == 1 && d[2])) return 8'h00;
    return tw[i];
  endfunction

  // check code, msb first
  function automatic logic [7:0] crc_of(input logic [7:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      c ^= sbyte(d, i);
      for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // full job: every strobe judged, optional second trigger while busy
  task automatic job(input logic [7:0] d, input bit poke);
    int k;
    k = 0;
    chk(lock_r[d[1:0]], 1'b0);
    wen(d);
    chk(busy_r, 1'b1);
    // one region at a time, bounded by the longest job
    for (int n = 0; n < 600 && busy_r === 1'b1; n++) begin
      @(posedge clock);
      #1;
      if (nv_strobe_r === 1'b1) begin
        while (k < 16 && d[1:0] == 2'h2 && ((k == 0 && d[3]) || (k == 1 && d[2]))) k++;
        chk(nv_region_r, d[1:0]);
        chk(nv_index_r, k);
        chk(nv_data_r, (k == 16) ? crc_of(d) : sbyte(d, k));
        k++;
      end
      wen_wr_valid = poke && (n == 4);
      wen_wr_data = 8'h82;
    end
    chk(busy_r, 1'b0);
    chk(k, 17);
    chk(lock_r[d[1:0]], 1'b1);
    chk(wen_r, d);
  endtask

  // trigger that must start nothing
  task automatic no_job(input logic [7:0] d);
    logic seen;
    seen = 1'b0;
    wen(d);
    repeat (20) begin
      @(posedge clock);
      #1 seen = seen | busy_r | nv_strobe_r;
    end
    chk(seen, 1'b0);
    chk(wen_r, d);
  endtask

  // shared block regions, base switching, locks and reserved code
  task automatic t_shared();
    do_reset();
    chk(wen_r, WEN_RESET);
    chk(lock_r, 3'h0);
    no_job(8'h02);
    for (int i = 0; i < 16; i++) mwr(2'h1, 4'(i), 8'h30 + 8'(i));
    chk(shared_base_r, 1'b1);
    mwr(2'h0, 4'h5, 8'hA5);
    chk(shared_base_r, 1'b0);
    rd(2'h0, 4'h4, 8'h34);
    job(8'h80, 1'b0);
    no_job(8'h80);
    job(8'h81, 1'b1);
    no_job(8'h83);
    no_job(8'h8F);
    repeat (8) @(posedge clock);
    #1 chk(error_r, 3'h0);
    $display("test shared done");
  endtask

  // region two under one exclusion setting
  task automatic t_two(input logic [7:0] ex);
    do_reset();
    for (int i = 0; i < 16; i++) mwr(2'h2, 4'(i), 8'h50 + 8'(i));
    job(8'h82 | ex, 1'b0);
    rd(2'h2, 4'h1, ex[2] ? 8'h00 : 8'h51);
    // untouched locked region must not be flagged
    repeat (60) @(posedge clock);
    #1 chk(error_r, 3'h0);
    mwr(2'h2, 4'h3, 8'hC3);
    rd(2'h2, 4'h3, 8'hC3);
    repeat (100) @(posedge clock);
    #1 chk(error_r[2], 1'b1);
    $display("test region two %0h done", ex);
  endtask

  initial begin
    t_shared();
    t_two(8'h00);
    t_two(8'h04);
    t_two(8'h08);
    t_two(8'h0C);
    end_of_test();
  end
endmodule // tb
